/* File: rtl/lse_pkg.sv */
// constants of the mechanical load shedding element: register map, fields, resets, timing
// assumes a single 25 MHz system clock and an APB register port
`default_nettype none
package lse_pkg;
	// clock and evaluation tick
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
	// widths
	localparam int ADDR_W = 8;
	localparam int CUR_W = 16;
	localparam int THR_W = 8;
	localparam int DLY_W = 6;
	localparam int EV_W = 4;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PICKUP = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DROPOUT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_T_PICKUP = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_T_DROP = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;
	// control fields
	localparam int CTRL_FUNC = 0;
	localparam int CTRL_ALLOW = 1;
	localparam int CTRL_ASG_A = 2;
	localparam int CTRL_ASG_B = 3;
	// status fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_BLOCK = 1;
	localparam int ST_ALARM = 2;
	localparam int ST_TRIP = 3;
	localparam int ST_IN_A = 4;
	localparam int ST_IN_B = 5;
	localparam int ST_RUN = 6;
	// interrupt event fields
	localparam int EV_SHED_ON = 0;
	localparam int EV_SHED_OFF = 1;
	localparam int EV_BLOCK = 2;
	localparam int EV_ALARM = 3;
	// thresholds in hundredths of full-load base current
	localparam logic [THR_W-1:0] THR_MIN = 8'h32;
	localparam logic [THR_W-1:0] THR_MAX = 8'h96;
	localparam logic [THR_W-1:0] PK_THR_RST = 8'h5a;
	localparam logic [THR_W-1:0] DP_THR_RST = 8'h32;
	// delays in ticks of tenths of a second
	localparam logic [DLY_W-1:0] DLY_MAX = 6'h32;
	localparam logic [DLY_W-1:0] DLY_RST = 6'h0a;
	localparam logic [DLY_W-1:0] CNT_SAT = 6'h3f;
endpackage : lse_pkg
`default_nettype wire

/* File: rtl/lse_load_shed_element.sv */
// load shedding element: threshold compare, pickup and dropout timers, blocking, APB registers
// assumes load_current and motor_running come from logic on clk_sys; block inputs are pins
// Function
// - shed output asserts after current stays above pickup beyond pickup delay
// - after current falls below dropout, shed holds until dropout delay elapses
// - thresholds and timers act only while motor runs; otherwise shed, trip and alarm inactive
// - pickup threshold is a multiple of base current, 0.50 to 1.50, reset 0.90
// - dropout threshold is a multiple of base current, 0.50 to 1.50, reset 0.50
// - function setting enables the element; default off, off means no active, alarm or trip indication, though the blocked flag still follows
// - either of two external block inputs blocks the element when blocking allowed
// - blocking allow defaults off and works only on an assigned block input
// - states of both external block inputs are readable as input status
`timescale 1ns/1ps
`default_nettype none
module lse_load_shed_element
	import lse_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CUR_W-1:0] load_current,
	input wire logic motor_running,
	input wire logic ext_block_in_a,
	input wire logic ext_block_in_b,
	output logic shed_contact,
	output logic active_o,
	output logic ext_blocked_flag,
	output logic alarm_o,
	output logic trip_o,
	output logic ext_block_st_a,
	output logic ext_block_st_b,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic in_a;
		logic in_b;
		logic func_en;
		logic allow;
		logic asg_a;
		logic asg_b;
		logic [THR_W-1:0] pk_thr;
		logic [THR_W-1:0] dp_thr;
		logic [DLY_W-1:0] t_pk;
		logic [DLY_W-1:0] t_dp;
		logic [31:0] div;
		logic [DLY_W-1:0] pk_cnt;
		logic [DLY_W-1:0] dp_cnt;
		logic shed;
		logic alarm;
		logic blocked;
		logic active;
		logic [EV_W-1:0] irq_st;
		logic [EV_W-1:0] irq_msk;
		logic irq;
		logic [31:0] prdata;
		logic [31:0] above_len;
		logic [31:0] below_len;
	} lse_state_t;

	lse_state_t st_r;
	lse_state_t st_nxt;
	logic setup_c;
	logic access_c;
	logic mapped_c;
	logic tick_c;
	logic run_ok_c;
	logic above_pk_c;
	logic below_dp_c;
	logic pk_done_c;
	logic dp_done_c;
	logic block_c;
	logic [EV_W-1:0] ev_c;
	logic [EV_W-1:0] clr_c;

	// limit a written threshold to its settable range
	function automatic logic [THR_W-1:0] lse_clamp_thr(input logic [31:0] v);
		logic [THR_W-1:0] r;
		r = THR_MIN;
		if (v > 32'(THR_MAX)) begin
			r = THR_MAX;
		end else if (v > 32'(THR_MIN)) begin
			r = v[THR_W-1:0];
		end
		return r;
	endfunction : lse_clamp_thr

	// limit a written delay to its settable range
	function automatic logic [DLY_W-1:0] lse_clamp_dly(input logic [31:0] v);
		logic [DLY_W-1:0] r;
		r = DLY_MAX;
		if (v < 32'(DLY_MAX)) begin
			r = v[DLY_W-1:0];
		end
		return r;
	endfunction : lse_clamp_dly

	////////////////////////////////////////////////////////////////////////////////
	// decode and compare terms

	// apb phases and address map
	assign setup_c = psel && !penable;
	assign access_c = psel && penable;
	assign mapped_c = (paddr == OFS_CTRL) || (paddr == OFS_PICKUP) || (paddr == OFS_DROPOUT) ||
		(paddr == OFS_T_PICKUP) || (paddr == OFS_T_DROP) || (paddr == OFS_STATUS) ||
		(paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
	assign tick_c = (st_r.div == 32'(TICK_LEN - 1));
	// an unassigned input never blocks, and blocking needs the allow setting
	assign block_c = st_r.allow && ((st_r.asg_a && st_r.in_a) || (st_r.asg_b && st_r.in_b));
	assign run_ok_c = st_r.func_en && motor_running && !block_c;
	assign above_pk_c = load_current > CUR_W'(st_r.pk_thr);
	assign below_dp_c = load_current < CUR_W'(st_r.dp_thr);
	// a zero delay acts at once; otherwise one tick more than the delay must pass, because the
	// free-running tick can fall right after the threshold is crossed
	assign pk_done_c = above_pk_c && (st_r.t_pk == '0 || st_r.pk_cnt > st_r.t_pk);
	assign dp_done_c = below_dp_c && (st_r.t_dp == '0 || st_r.dp_cnt > st_r.t_dp);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// one pass builds the whole next state
	always_comb begin
		st_nxt = st_r;
		ev_c = '0;
		clr_c = '0;
		// block pins: three flops, change taken once second and third agree
		st_nxt.sync_a = {st_r.sync_a[1:0], ext_block_in_a};
		st_nxt.sync_b = {st_r.sync_b[1:0], ext_block_in_b};
		if (st_r.sync_a[1] == st_r.sync_a[2]) begin
			st_nxt.in_a = st_r.sync_a[2];
		end
		if (st_r.sync_b[1] == st_r.sync_b[2]) begin
			st_nxt.in_b = st_r.sync_b[2];
		end
		// evaluation tick divider
		st_nxt.div = tick_c ? '0 : st_r.div + 32'h0000_0001;
		st_nxt.blocked = block_c;
		st_nxt.active = st_r.func_en;
		if (!run_ok_c) begin
			// off, stopped or blocked: shed, alarm and timers cleared
			st_nxt.shed = 1'b0;
			st_nxt.alarm = 1'b0;
			st_nxt.pk_cnt = '0;
			st_nxt.dp_cnt = '0;
		end else begin
			st_nxt.alarm = above_pk_c;
			if (!st_r.shed) begin
				st_nxt.dp_cnt = '0;
				if (!above_pk_c) begin
					st_nxt.pk_cnt = '0;
				end else if (pk_done_c) begin
					st_nxt.shed = 1'b1;
					st_nxt.pk_cnt = '0;
				end else if (tick_c && st_r.pk_cnt != CNT_SAT) begin
					st_nxt.pk_cnt = st_r.pk_cnt + 6'h01;
				end
			end else begin
				st_nxt.pk_cnt = '0;
				if (!below_dp_c) begin
					st_nxt.dp_cnt = '0;
				end else if (dp_done_c) begin
					st_nxt.shed = 1'b0;
					st_nxt.dp_cnt = '0;
				end else if (tick_c && st_r.dp_cnt != CNT_SAT) begin
					st_nxt.dp_cnt = st_r.dp_cnt + 6'h01;
				end
			end
		end
		// apb read data captured in the setup cycle
		if (setup_c && !pwrite) begin
			case (paddr)
				OFS_CTRL: st_nxt.prdata = {28'h000_0000, st_r.asg_b, st_r.asg_a, st_r.allow,
					st_r.func_en};
				OFS_PICKUP: st_nxt.prdata = {24'h00_0000, st_r.pk_thr};
				OFS_DROPOUT: st_nxt.prdata = {24'h00_0000, st_r.dp_thr};
				OFS_T_PICKUP: st_nxt.prdata = {26'h000_0000, st_r.t_pk};
				OFS_T_DROP: st_nxt.prdata = {26'h000_0000, st_r.t_dp};
				OFS_STATUS: st_nxt.prdata = {25'h000_0000, motor_running, st_r.in_b, st_r.in_a,
					st_r.shed, st_r.alarm, st_r.blocked, st_r.active};
				OFS_IRQ_STAT: st_nxt.prdata = {28'h000_0000, st_r.irq_st};
				OFS_IRQ_MASK: st_nxt.prdata = {28'h000_0000, st_r.irq_msk};
				default: st_nxt.prdata = '0;
			endcase
		end
		// apb writes and read-clear take effect in the access cycle
		if (access_c && pwrite) begin
			case (paddr)
				OFS_CTRL: begin
					st_nxt.func_en = pwdata[CTRL_FUNC];
					st_nxt.allow = pwdata[CTRL_ALLOW];
					st_nxt.asg_a = pwdata[CTRL_ASG_A];
					st_nxt.asg_b = pwdata[CTRL_ASG_B];
				end
				OFS_PICKUP: st_nxt.pk_thr = lse_clamp_thr(pwdata);
				OFS_DROPOUT: st_nxt.dp_thr = lse_clamp_thr(pwdata);
				OFS_T_PICKUP: st_nxt.t_pk = lse_clamp_dly(pwdata);
				OFS_T_DROP: st_nxt.t_dp = lse_clamp_dly(pwdata);
				OFS_IRQ_MASK: st_nxt.irq_msk = pwdata[EV_W-1:0];
				default: st_nxt.irq_msk = st_r.irq_msk;
			endcase
		end
		if (access_c && !pwrite && paddr == OFS_IRQ_STAT) begin
			clr_c = st_r.irq_st;
		end
		// run lengths above pickup and below dropout, watched by the delay assertions
		if (!(run_ok_c && !st_r.shed && above_pk_c)) begin
			st_nxt.above_len = '0;
		end else if (st_r.above_len != 32'hffff_ffff) begin
			st_nxt.above_len = st_r.above_len + 32'h0000_0001;
		end
		if (!(run_ok_c && st_r.shed && below_dp_c)) begin
			st_nxt.below_len = '0;
		end else if (st_r.below_len != 32'hffff_ffff) begin
			st_nxt.below_len = st_r.below_len + 32'h0000_0001;
		end
		// sticky events, a new event wins over a clear in the same cycle
		ev_c[EV_SHED_ON] = st_nxt.shed && !st_r.shed;
		ev_c[EV_SHED_OFF] = !st_nxt.shed && st_r.shed;
		ev_c[EV_BLOCK] = st_nxt.blocked && !st_r.blocked;
		ev_c[EV_ALARM] = st_nxt.alarm && !st_r.alarm;
		st_nxt.irq_st = (st_r.irq_st & ~clr_c) | ev_c;
		st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// reset loads constants only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.pk_thr <= PK_THR_RST;
			st_r.dp_thr <= DP_THR_RST;
			st_r.t_pk <= DLY_RST;
			st_r.t_dp <= DLY_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// all from the state register except the apb handshake
	assign prdata = st_r.prdata;
	assign pready = 1'b1;
	assign pslverr = access_c && !mapped_c;
	assign shed_contact = st_r.shed;
	assign trip_o = st_r.shed;
	assign alarm_o = st_r.alarm;
	assign active_o = st_r.active;
	assign ext_blocked_flag = st_r.blocked;
	assign ext_block_st_a = st_r.in_a;
	assign ext_block_st_b = st_r.in_b;
	assign irq = st_r.irq;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_pick_ready;
		run_ok_c && !st_r.shed && pk_done_c;
	endsequence

	sequence s_drop_ready;
		run_ok_c && st_r.shed && dp_done_c;
	endsequence

	// overdue: a full tick more than the delay has passed with the condition held
	sequence s_pick_overdue;
		run_ok_c && !st_r.shed && above_pk_c &&
			st_r.above_len >= 32'(TICK_LEN) * (32'(st_r.t_pk) + 32'h0000_0001);
	endsequence

	sequence s_drop_overdue;
		run_ok_c && st_r.shed && below_dp_c &&
			st_r.below_len >= 32'(TICK_LEN) * (32'(st_r.t_dp) + 32'h0000_0001);
	endsequence

	a_shed_sets_after: assert property (s_pick_ready |=> st_r.shed)
		else $error("shed did not assert after pickup delay");
	a_shed_needs_delay: assert property ($rose(st_r.shed) |-> $past(pk_done_c))
		else $error("shed asserted before pickup delay");
	a_drop_releases: assert property (s_drop_ready |=> !st_r.shed)
		else $error("shed did not release after dropout delay");
	a_drop_holds: assert property ($fell(st_r.shed) |-> $past(dp_done_c) || !$past(run_ok_c))
		else $error("shed released early");
	a_stop_clears: assert property (!motor_running |=> !shed_contact && !alarm_o && st_r.pk_cnt == '0)
		else $error("outputs active while motor not running");
	a_pick_range: assert property (st_r.pk_thr >= THR_MIN && st_r.pk_thr <= THR_MAX)
		else $error("pickup threshold out of range");
	a_drop_range: assert property (st_r.dp_thr >= THR_MIN && st_r.dp_thr <= THR_MAX)
		else $error("dropout threshold out of range");
	a_func_off_quiet: assert property (!st_r.func_en |=> !active_o && !alarm_o && !trip_o)
		else $error("indication while function off");
	a_block_pin: assert property (st_r.allow && st_r.asg_a && st_r.in_a |=> ext_blocked_flag ##1 !trip_o)
		else $error("assigned block input did not block");
	a_unassigned_free: assert property (!st_r.asg_a && !st_r.asg_b |=> !ext_blocked_flag)
		else $error("unassigned input blocked");
	a_in_status: assert property (st_r.sync_a[2] == st_r.sync_a[1] |=> ext_block_st_a == $past(st_r.sync_a[2]))
		else $error("block input status wrong");
	a_trip_follows: assert property (trip_o == shed_contact && (!alarm_o || active_o))
		else $error("trip and shed disagree");
	a_hyst_hold: assert property (st_r.shed && run_ok_c && !below_dp_c |=> st_r.shed)
		else $error("shed dropped between thresholds");
	a_pk_restart: assert property (run_ok_c && !st_r.shed && !above_pk_c |=> st_r.pk_cnt == '0)
		else $error("pickup timer not restarted");
	// delay bounds counted in clock cycles, independent of the tick counters
	a_pick_min_time: assert property ($rose(st_r.shed) |->
		$past(st_r.above_len) >= 32'(TICK_LEN) * 32'($past(st_r.t_pk)))
		else $error("shed asserted before the pickup time");
	a_pick_max_time: assert property (s_pick_overdue |=> st_r.shed)
		else $error("shed late after the pickup time");
	a_drop_min_time: assert property ($fell(st_r.shed) && $past(run_ok_c) |->
		$past(st_r.below_len) >= 32'(TICK_LEN) * 32'($past(st_r.t_dp)))
		else $error("shed released before the dropout time");
	a_drop_max_time: assert property (s_drop_overdue |=> !st_r.shed)
		else $error("shed held past the dropout time");
	// blocking, alarm and interrupt event behaviour
	a_block_clears: assert property (block_c |=> ext_blocked_flag && !alarm_o && !trip_o &&
		st_r.pk_cnt == '0 && st_r.dp_cnt == '0)
		else $error("blocking left alarm, trip or timers set");
	a_alarm_tracks: assert property (run_ok_c |=> alarm_o == $past(above_pk_c))
		else $error("alarm does not follow the pickup compare");
	a_irq_set_wins: assert property ($rose(st_r.shed) |-> st_r.irq_st[EV_SHED_ON])
		else $error("shed event not recorded");

endmodule : lse_load_shed_element
`default_nettype wire

/* File: testbench/lse_process_model.sv */
// driven process model: its load current follows the demand, one clock late
// assumes the bench changes the demand just after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module lse_process_model
	import lse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic shed_contact,
	input wire logic [CUR_W-1:0] demand,
	output logic [CUR_W-1:0] load_current
);
	// the bench lowers the demand itself when it wants flow cut
	always_ff @(posedge clk_sys) begin
		load_current <= demand;
	end
endmodule : lse_process_model
`default_nettype wire

/* File: testbench/tb_lse_load_shed_element.sv */
// testbench of the load shedding element: apb tasks and sequences of calls
// assumes lse_pkg and the process model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_lse_load_shed_element
	import lse_pkg::*;
;
	logic clk_sys, rst, psel, penable, pwrite, run, blk_a, blk_b;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, shed, act, blkd, alarm, trip, st_a, st_b, irq, err_seen;
	logic [CUR_W-1:0] demand, cur;
	int errors, n_checks;

	lse_load_shed_element #(.TICK_LEN(10)) DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .load_current(cur), .motor_running(run),
		.ext_block_in_a(blk_a), .ext_block_in_b(blk_b), .shed_contact(shed), .active_o(act),
		.ext_blocked_flag(blkd), .alarm_o(alarm), .trip_o(trip), .ext_block_st_a(st_a),
		.ext_block_st_b(st_b), .irq(irq));
	lse_process_model proc (.clk_sys(clk_sys), .shed_contact(shed), .demand(demand),
		.load_current(cur));

////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			give_verdict();
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// bounded wait for the shed contact, with a lower bound on the delay
	task automatic wait_shed(input logic exp, input int lo, input int hi);
		int n;
		n = 0;
		while (shed !== exp && n < hi) begin
			@(posedge clk_sys);
			n++;
		end
		chk("shed", shed, exp);
		chk("delay", n >= lo, 1'b1);
	endtask : wait_shed

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

////////////////////////////////////////
	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// main sequence
	initial begin
		errors = 0;
		n_checks = 0;
		{rst, psel, penable, pwrite, run, blk_a, blk_b} = 7'h40;
		paddr = 8'h00;
		pwdata = 32'h0;
		demand = 16'h0000;
		wt(5);
		rst <= 1'b0;
		// reset values and an unmapped address
		apb(1'b0, OFS_CTRL, 32'h0); chk("ctrl", rd, 32'h0);
		apb(1'b0, OFS_PICKUP, 32'h0); chk("pickup", rd, 32'h5a);
		apb(1'b0, OFS_DROPOUT, 32'h0); chk("dropout", rd, 32'h32);
		apb(1'b0, OFS_T_PICKUP, 32'h0); chk("t_pick", rd, 32'h0a);
		apb(1'b0, OFS_T_DROP, 32'h0); chk("t_drop", rd, 32'h0a);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", err_seen, 1'b1);
		// function off: high current gives no indication
		run <= 1'b1;
		demand <= 16'h00c8;
		wt(40);
		chk("off", {act, alarm, trip}, 3'h0);
		// range clamps, then working settings
		apb(1'b1, OFS_PICKUP, 32'hff);
		apb(1'b0, OFS_PICKUP, 32'h0); chk("pk_max", rd, 32'h96);
		apb(1'b1, OFS_DROPOUT, 32'h10);
		apb(1'b0, OFS_DROPOUT, 32'h0); chk("dp_min", rd, 32'h32);
		apb(1'b1, OFS_PICKUP, 32'h64);
		apb(1'b1, OFS_DROPOUT, 32'h3c);
		apb(1'b1, OFS_T_PICKUP, 32'h2);
		apb(1'b1, OFS_T_DROP, 32'h3);
		apb(1'b1, OFS_IRQ_MASK, 32'h1);
		demand <= 16'h0050;
		apb(1'b1, OFS_CTRL, 32'h1);
		wt(2);
		chk("active", act, 1'b1);
		// pickup timer restarts after a dip, then picks up after two ticks
		demand <= 16'h0078;
		wt(15);
		chk("alarm", alarm, 1'b1);
		demand <= 16'h0050;
		wt(1);
		demand <= 16'h0078;
		wait_shed(1'b1, 19, 40);
		chk("trip_irq", {trip, irq}, 2'h3);
		// between thresholds the shed state holds
		demand <= 16'h0050;
		wt(60);
		chk("hold", {shed, alarm}, 2'h2);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("irq_st", rd[3:0], 4'h9);
		wt(2);
		chk("irq_clr", irq, 1'b0);
		// dropout after three ticks below dropout
		demand <= 16'h0028;
		wait_shed(1'b0, 29, 50);
		apb(1'b0, OFS_STATUS, 32'h0); chk("status", rd[6:0], 7'h41);
		// motor stop clears shedding
		apb(1'b1, OFS_T_PICKUP, 32'h0);
		demand <= 16'h0078;
		wait_shed(1'b1, 0, 10);
		run <= 1'b0;
		wt(3);
		chk("stop", {shed, alarm}, 2'h0);
		run <= 1'b1;
		wait_shed(1'b1, 0, 10);
		// blocking needs allow, assignment and a true input
		blk_a <= 1'b1;
		wt(8);
		chk("in_a", {st_a, blkd, shed}, 3'h5);
		apb(1'b1, OFS_CTRL, 32'h3);
		wt(8);
		chk("no_asg", blkd, 1'b0);
		apb(1'b1, OFS_CTRL, 32'hb);
		wt(8);
		chk("b_low", blkd, 1'b0);
		blk_b <= 1'b1;
		wt(8);
		chk("blk_b", {st_b, blkd, shed, alarm}, 4'hc);
		blk_b <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h7);
		wt(8);
		chk("blk_a", {blkd, trip}, 2'h2);
		give_verdict();
	end
endmodule : tb_lse_load_shed_element
`default_nettype wire
